// *** rtl/ofs_top.sv ***
// Output fault supervisor for a five-channel high-side switch: filters
// faults, gates outputs and keeps latched status for software.
// Assumes raw fault inputs are asynchronous and software uses Avalon-MM.
//
// Functional notes
// - Filtered over-temperature switches its channel off.
// - Over-temperature flagged in quick and channel status.
// - Over-temperature flag clears after condition gone, read.
// - Fail mode: over-temperature restart needs mode transition.
// - Undervoltage sets summary flag and supply-low flag.
// - Supply-low clears after recovery and status read.
// - Fail mode autorestarts outputs after undervoltage.
// - Overvoltage sets summary flag and supply-high flag.
// - Supply-high clears after recovery and status read.
// - Supply faults deglitched by filter interval.
// - Outputs off until pump settles; commands held.
// - Filtered pump fault disables all outputs.
// - Pump fault sets summary and pump fault flag.
// - Commands during pump fault execute when valid.
// - Pump fault flag clears after recovery, quick read.
module ofs_top (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  input  wire ofs_pkg::ofs_cond_s  cond_raw,
  input  wire logic                pump_settled_raw,
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  output logic [1:0]               avs_response,
  output logic [4:0]               out_on,
  output logic [4:0]               inrush_current_window,
  output logic                     irq
);
  import ofs_pkg::*;

  // Synchronised and filtered fault conditions.
  ofs_cond_s         cond_sync;
  logic              pump_settled_sync;
  logic [4:0]        over_temp_shutdown;
  logic              supply_low_cond;
  logic              supply_high_cond;
  logic              pump_bad_cond;

  // Latched status flags.
  logic [4:0]        ots_flag;
  logic              supply_low_flag;
  logic              supply_high_flag;
  logic              pump_fault_flag;
  // Command, block and mode state.
  logic [4:0]        ots_block;
  logic              low_block;
  logic [4:0]        cmd_on;
  logic              fail_mode;
  logic              fail_mode_q;
  // Interrupt and output state.
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [4:0]        out_q;
  ofs_gate_e         gate_state;

  // Raw comparator levels come from analog sense logic, so each crosses two
  // flops before any decision; this adds two cycles to every reaction time.
  ofs_sync #(.W(9)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in ({cond_raw, pump_settled_raw}),
    .sync_out ({cond_sync, pump_settled_sync})
  );

  // Per-channel over-temperature deglitch.
  // Each channel keeps its own filter so one hot channel never delays another.
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_ots
      ofs_filter #(.CYC(OTS_FILTER_CYC)) u_f (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .raw      (cond_sync.over_temp[g]),
        .filt     (over_temp_shutdown[g])
      );
    end
  endgenerate

  // Supply faults are filtered apart, so a brief overvoltage never hides
  // an undervoltage that follows it.
  ofs_filter #(.CYC(SUPP_FILTER_CYC)) u_f_low (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .raw      (cond_sync.supply_low),
    .filt     (supply_low_cond)
  );

  ofs_filter #(.CYC(SUPP_FILTER_CYC)) u_f_high (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .raw      (cond_sync.supply_high),
    .filt     (supply_high_cond)
  );

  // Pump validity filter; a flicker shorter than the filter never blocks outputs.
  ofs_filter #(.CYC(PUMP_FILTER_CYC)) u_f_pump (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .raw      (cond_sync.pump_bad),
    .filt     (pump_bad_cond)
  );

  // Bus decode; every access answers in the cycle after it is seen.
  // Decode reads the held request directly, since the master keeps address
  // and data steady until the answer edge.
  // Writes act only with byte lane 0 enabled, since every writable field sits in it.
  wire        acc        = (avs_read | avs_write) & avs_waitrequest & clk_en;
  wire        do_wr      = avs_write & acc & avs_byteenable[0];
  wire        do_rd      = avs_read & acc;
  wire [5:0]  ch_off     = avs_address - ADDR_CH_BASE;
  wire        hit_ch     = (avs_address >= ADDR_CH_BASE) && (avs_address < ADDR_DEVST)
                           && (avs_address[1:0] == 2'b00);
  wire [2:0]  ch_idx     = ch_off[4:2];
  wire        hit_quick  = avs_address == ADDR_QUICK;
  wire        hit_devst  = avs_address == ADDR_DEVST;
  wire        hit_outctl = avs_address == ADDR_OUTCTL;
  wire        hit_mode   = avs_address == ADDR_MODE;
  wire        hit_ist    = avs_address == ADDR_IRQ_ST;
  wire        hit_imsk   = avs_address == ADDR_IRQ_MSK;
  wire        hit_any    = hit_ch | hit_quick | hit_devst | hit_outctl | hit_mode
                           | hit_ist | hit_imsk;
  wire        rd_quick   = do_rd & hit_quick;
  wire        rd_devst   = do_rd & hit_devst;
  wire        rd_ist     = do_rd & hit_ist;
  wire        dev_fault  = supply_low_flag | supply_high_flag | pump_fault_flag;

  // Channel-addressed decode, one strobe per channel.
  // An output control write counts as an on-bit write for every channel;
  // ch_idx only means something while hit_ch is high.
  logic [4:0] wr_ch_on;
  logic [4:0] rd_ch;
  logic [4:0] new_on;
  generate
    for (g = 0; g < 5; g++) begin : g_dec
      assign wr_ch_on[g] = (do_wr & hit_ch & (ch_idx == 3'(g))) | (do_wr & hit_outctl);
      assign rd_ch[g]    = do_rd & hit_ch & (ch_idx == 3'(g));
      assign new_on[g]   = hit_outctl ? avs_writedata[g] : avs_writedata[BIT_CH_ON];
    end
  endgenerate

  // A mode change in either direction counts as a mode transition.
  wire        mode_trans = fail_mode != fail_mode_q;

  // Per-channel flags: set wins over a clearing read.
  logic [4:0] next_ots_flag;
  logic [4:0] next_ots_block;
  logic [4:0] next_cmd_on;
  generate
    for (g = 0; g < 5; g++) begin : g_flag
      assign next_ots_flag[g] = over_temp_shutdown[g] |
                                (ots_flag[g] & ~rd_ch[g]);
      // Block holds until an on-bit rewrite in normal mode or any mode transition.
      // The transition is seen a cycle after the mode bit moves, so it must not
      // depend on the new mode, or leaving fail mode would never free a channel.
      assign next_ots_block[g] = over_temp_shutdown[g] |
                                 (ots_block[g] & ~(mode_trans |
                                                   (~fail_mode & wr_ch_on[g])));
      assign next_cmd_on[g] = wr_ch_on[g] ? new_on[g] : cmd_on[g];
    end
  endgenerate

  // Channel flag, block and command registers.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ots_flag  <= '0;
      ots_block <= '0;
      cmd_on    <= OUTCTL_RST;
    end else if (clk_en) begin
      ots_flag  <= next_ots_flag;
      ots_block <= next_ots_block;
      cmd_on    <= next_cmd_on;
    end
  end

  // Device flags clear only once the filtered condition is gone.
  // A read that meets a still-present condition leaves the flag set, so
  // software is sure to see the flag high at least once.
  wire next_low_flag  = supply_low_cond | (supply_low_flag & ~rd_devst);
  wire next_high_flag = supply_high_cond | (supply_high_flag & ~rd_devst);
  wire next_pump_flag = pump_bad_cond | (pump_fault_flag & ~rd_quick);
  // Normal mode needs an on-bit write after undervoltage; fail mode restarts itself.
  wire next_low_block = ~fail_mode & (supply_low_cond |
                        (low_block & ~(|wr_ch_on)));

  // Device flag and undervoltage block registers.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      supply_low_flag  <= 1'b0;
      supply_high_flag <= 1'b0;
      pump_fault_flag  <= 1'b0;
      low_block        <= 1'b0;
    end else if (clk_en) begin
      supply_low_flag  <= next_low_flag;
      supply_high_flag <= next_high_flag;
      pump_fault_flag  <= next_pump_flag;
      low_block        <= next_low_block;
    end
  end

  // Mode bit and its copy one cycle late; the two differ for one cycle per change.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fail_mode   <= FAIL_RST;
      fail_mode_q <= FAIL_RST;
    end else if (clk_en) begin
      fail_mode_q <= fail_mode;
      if (do_wr && hit_mode) begin
        fail_mode <= avs_writedata[0];
      end
    end
  end

  // Pump gate: held commands wait rather than being dropped.
  // Limitation: the settle input is watched only after reset; a later loss of
  // the pump is left to the pump fault comparator.
  ofs_gate_e next_gate;
  always_comb begin
    next_gate = gate_state;
    case (gate_state)
      OFS_PUMP_UP: if (pump_settled_sync && !pump_bad_cond) next_gate = OFS_RUN;
      OFS_RUN:     if (pump_bad_cond) next_gate = OFS_BLOCKED;
      OFS_BLOCKED: if (!pump_bad_cond) next_gate = OFS_RUN;
      default:     next_gate = OFS_PUMP_UP;
    endcase
  end

  // Pump gate state register.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gate_state <= OFS_PUMP_UP;
    end else if (clk_en) begin
      gate_state <= next_gate;
    end
  end

  // Output drive: commanded, not blocked, supply present, pump valid.
  // Trade-off: a hot channel is dropped through the next block value, so it
  // goes off in the cycle the filter fires at the cost of a longer path.
  wire        pump_ok  = gate_state == OFS_RUN;
  wire [4:0]  next_out = cmd_on & ~ots_block & ~next_ots_block
                         & {5{pump_ok & ~supply_low_cond & ~low_block}};
  // Rising edge of an output starts the inrush window, also after deferral.
  wire [4:0]  next_inrush = next_out & ~out_q;

  // Output registers; out_q is an inner copy so the edge detector reads no port.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_q                 <= '0;
      out_on                <= '0;
      inrush_current_window <= '0;
    end else if (clk_en) begin
      out_q                 <= next_out;
      out_on                <= next_out;
      inrush_current_window <= next_inrush;
    end
  end

  // Interrupt sources: new rising events of each latched flag.
  // A fault that stays present raises one event, not one per cycle.
  wire [IRQ_W-1:0] irq_evt = {pump_bad_cond & ~pump_fault_flag,
                              supply_high_cond & ~supply_high_flag,
                              supply_low_cond & ~supply_low_flag,
                              over_temp_shutdown & ~ots_flag};
  wire [IRQ_W-1:0] next_irq_st = irq_evt | (irq_status & {IRQ_W{~rd_ist}});

  // Read data mux; summary flag appears in the quick, channel and device status registers, not in interrupt status.
  // Unmapped addresses read as zero; the response code tells software why.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_quick) begin
      rd_mux[4:0]      = ots_flag;
      rd_mux[BIT_PUMP] = pump_fault_flag;
      rd_mux[BIT_DFS]  = dev_fault;
    end else if (hit_ch) begin
      rd_mux[BIT_CH_ON]  = cmd_on[ch_idx];
      rd_mux[BIT_CH_OTS] = ots_flag[ch_idx];
      rd_mux[BIT_DFS]    = dev_fault;
    end else if (hit_devst) begin
      rd_mux[BIT_LOW]  = supply_low_flag;
      rd_mux[BIT_HIGH] = supply_high_flag;
      rd_mux[BIT_DFS]  = dev_fault;
    end else if (hit_outctl) begin
      rd_mux[4:0] = cmd_on;
    end else if (hit_mode) begin
      rd_mux[0] = fail_mode;
    end else if (hit_ist) begin
      rd_mux[IRQ_W-1:0] = irq_status;
    end else if (hit_imsk) begin
      rd_mux[IRQ_W-1:0] = irq_mask;
    end
  end

  // Bus answer registers; waitrequest drops for exactly one cycle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= 2'b00;
    end else if (clk_en) begin
      avs_waitrequest <= ~acc;
      if (acc) begin
        avs_readdata <= rd_mux;
        avs_response <= hit_any ? 2'b00 : 2'b11;
      end
    end
  end

  // Interrupt registers; the output is registered so it never glitches while
  // status and mask settle in the same cycle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_status <= '0;
      irq_mask   <= MASK_RST;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_status <= next_irq_st;
      if (do_wr && hit_imsk) begin
        irq_mask <= avs_writedata[IRQ_W-1:0];
      end
      irq <= |(next_irq_st & irq_mask);
    end
  end

endmodule

// *** rtl/ofs_pkg.sv ***
// Package for the output fault supervisor: register map, field layout,
// reset values and deglitch counts.
// Assumes a 125 MHz core clock and a 32-bit Avalon-MM register slave.
package ofs_pkg;

  localparam int unsigned NUM_CH   = 5;
  localparam int unsigned CLK_MHZ  = 125;

  // Deglitch times in nanoseconds, typical figures.
  localparam int unsigned OTS_FILTER_NS  = 5000;
  localparam int unsigned SUPP_FILTER_NS = 3500;
  localparam int unsigned PUMP_FILTER_NS = 4000;
  localparam int unsigned OTS_FILTER_CYC  = OTS_FILTER_NS * CLK_MHZ / 1000;
  localparam int unsigned SUPP_FILTER_CYC = SUPP_FILTER_NS * CLK_MHZ / 1000;
  localparam int unsigned PUMP_FILTER_CYC = PUMP_FILTER_NS * CLK_MHZ / 1000;
  localparam int unsigned FILT_W = 10;

  // Byte addresses of the registers.
  localparam logic [5:0] ADDR_QUICK   = 6'h04;
  localparam logic [5:0] ADDR_CH_BASE = 6'h08;
  localparam logic [5:0] ADDR_DEVST   = 6'h1C;
  localparam logic [5:0] ADDR_OUTCTL  = 6'h20;
  localparam logic [5:0] ADDR_MODE    = 6'h24;
  localparam logic [5:0] ADDR_IRQ_ST  = 6'h28;
  localparam logic [5:0] ADDR_IRQ_MSK = 6'h2C;

  // Field positions.
  localparam int unsigned BIT_DFS    = 31;
  localparam int unsigned BIT_PUMP   = 8;
  localparam int unsigned BIT_CH_ON  = 0;
  localparam int unsigned BIT_CH_OTS = 1;
  localparam int unsigned BIT_LOW    = 0;
  localparam int unsigned BIT_HIGH   = 1;

  // Reset values.
  localparam logic [4:0] OUTCTL_RST = 5'h00;
  localparam logic       FAIL_RST   = 1'b0;
  localparam logic [7:0] MASK_RST   = 8'h00;

  // Interrupt status layout: bits 4:0 channel shutdowns, 5 low, 6 high, 7 pump.
  localparam int unsigned IRQ_W = 8;

  typedef struct packed {
    logic [4:0] over_temp;
    logic       supply_low;
    logic       supply_high;
    logic       pump_bad;
  } ofs_cond_s;

  typedef enum logic [1:0] {
    OFS_RUN      = 2'b00,
    OFS_BLOCKED  = 2'b01,
    OFS_PUMP_UP  = 2'b10
  } ofs_gate_e;

endpackage

// *** rtl/ofs_sync.sv ***
// Two-flop synchroniser for asynchronous fault comparator inputs.
// Assumes the input arrives from analog sense logic outside core_clk.
module ofs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // First stage feeds only the second stage to contain metastability.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// *** rtl/ofs_filter.sv ***
// Deglitch filter: the output follows the input only after it has held
// steady for CYC cycles.
// Assumes a synchronised input on core_clk.
module ofs_filter #(
  parameter int unsigned CYC = 16
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic raw,
  output logic      filt
);
  import ofs_pkg::*;

  logic [FILT_W-1:0] cnt;
  localparam logic [FILT_W-1:0] LAST = FILT_W'(CYC - 1);

  // Counter restarts whenever the input agrees with the output, so short glitches never pass.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt  <= '0;
      filt <= 1'b0;
    end else if (clk_en) begin
      if (raw == filt) begin
        cnt <= '0;
      end else if (cnt == LAST) begin
        cnt  <= '0;
        filt <= raw;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

// *** verification/ofs_top_chk.sv ***
// Checker for the output fault supervisor, bound to its top module.
// Assumes one core_clk domain and a clock enable that is held high.
module ofs_top_chk (
  input wire logic               core_clk,
  input wire logic               reset,
  input wire ofs_pkg::ofs_cond_s cond_raw,
  input wire logic               pump_settled_raw,
  input wire logic [5:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest,
  input wire logic [1:0]         avs_response,
  input wire logic [31:0]        avs_readdata,
  input wire logic [4:0]         out_on
);
  import ofs_pkg::*;
  // Margins cover the two sync flops and the output register after the filter.
  localparam int LIM_S = SUPP_FILTER_CYC + 8;
  localparam int LIM_O = OTS_FILTER_CYC + 8;
  localparam int LIM_P = PUMP_FILTER_CYC + 8;
  logic [9:0] n_lo;
  logic [9:0] n_pf;
  logic [9:0] n_ot;

  // Saturating counts of how long undervoltage, pump fault and channel 0 over-temperature have each stood without a break.
  always_ff @(posedge core_clk) begin
    n_lo <= (reset || !cond_raw.supply_low) ? 10'h0 : n_lo + 10'(n_lo != 10'h3ff);
    n_pf <= (reset || !cond_raw.pump_bad) ? 10'h0 : n_pf + 10'(n_pf != 10'h3ff);
    n_ot <= (reset || !cond_raw.over_temp[0]) ? 10'h0 : n_ot + 10'(n_ot != 10'h3ff);
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_unmap; !avs_waitrequest && avs_read && avs_address > 6'h2c |-> avs_response == 2'h3;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_settle; !pump_settled_raw [*6] |-> out_on == 5'h0; endproperty
  a_settle: assert property (p_settle) else $error("output on before pump settled");
  property p_ot; n_ot >= LIM_O |-> !out_on[0]; endproperty
  a_ot: assert property (p_ot) else $error("hot channel still on");
  property p_low; n_lo >= LIM_S |-> out_on == 5'h0; endproperty
  a_low: assert property (p_low) else $error("output on in undervoltage");
  property p_pump; n_pf >= LIM_P |-> out_on == 5'h0; endproperty
  a_pump: assert property (p_pump) else $error("output on in pump fault");
  property p_lowf;
    !avs_waitrequest && avs_read && avs_address == ADDR_DEVST && n_lo >= LIM_S
      |-> avs_readdata[BIT_LOW] && avs_readdata[BIT_DFS];
  endproperty
  a_lowf: assert property (p_lowf) else $error("supply low not flagged");
endmodule

bind ofs_top ofs_top_chk chk (.core_clk, .reset, .cond_raw, .pump_settled_raw, .avs_address,
  .avs_read, .avs_write, .avs_waitrequest, .avs_response, .avs_readdata, .out_on);

// *** verification/ofs_fault_src.sv ***
// Sense model: raw comparator lines that follow the levels the bench asks for.
// Assumes requests change just after a core_clk edge.
module ofs_fault_src (
  input  wire logic               core_clk,
  input  wire ofs_pkg::ofs_cond_s want,
  input  wire logic               pump_ok,
  output ofs_pkg::ofs_cond_s      cond_raw,
  output logic                    pump_settled_raw
);
  import ofs_pkg::*;
  // The pump starts unsettled, as at power-up.
  initial begin
    cond_raw         = '0;
    pump_settled_raw = 1'h0;
  end
  // The lines follow the bench a cycle late, like a comparator with its own delay.
  always @(posedge core_clk) begin
    cond_raw         <= want;
    pump_settled_raw <= pump_ok;
  end
endmodule

// *** verification/ofs_top_tb.sv ***
// Bench for the output fault supervisor: Avalon-MM tasks and fault scenarios.
// Assumes the sense model drives the raw fault lines and the checker is bound.
module ofs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ofs_pkg::*;
  logic        core_clk, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic        pump_ok, pump_settled_raw;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_data;
  logic [1:0]  avs_response, rd_resp;
  logic [4:0]  out_on, inrush_current_window, inrush_seen;
  ofs_cond_s   want, cond_raw;
  int          miscompares, compares;

  ofs_top uut (.core_clk, .reset, .clk_en(1'h1), .cond_raw, .pump_settled_raw, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .avs_response, .out_on, .inrush_current_window, .irq);
  ofs_fault_src src (.core_clk, .want, .pump_ok, .cond_raw, .pump_settled_raw);

  // Clock at 125 MHz.
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  // Collect inrush pulses, since a one-cycle pulse falls between checks.
  always @(posedge core_clk) inrush_seen <= inrush_seen | inrush_current_window;

  // Print the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare with case equality so an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One bus access, held until waitrequest is seen low at a rising edge.
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 40);
    rd_data = avs_readdata;
    rd_resp = avs_response;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 40) begin
      miscompares++;
      $display("unexpected at %0t: bus hang", $time);
      stop_test();
    end
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(rd_data & m, e, "read data");
    chk(32'(rd_resp), 32'h0, "response");
  endtask

  // Raise a fault, wait out sync and filter, then look at its flags.
  task automatic fault(input ofs_cond_s f, input int n, input logic [5:0] a,
                       input logic [31:0] m, input logic [31:0] q);
    @(posedge core_clk);
    want <= f;
    cyc(n + 12);
    rdc(a, m, m);
    rdc(ADDR_QUICK, q, q);
  endtask

  // Remove the fault: the flag must survive until the first read after recovery.
  task automatic heal(input int n, input logic [5:0] a, input logic [31:0] m);
    @(posedge core_clk);
    want <= '0;
    cyc(n + 12);
    rdc(a, m, m);
    rdc(a, m, 32'h0);
  endtask

  // Main sequence; every input is driven just after a rising edge.
  initial begin
    reset         = 1'h1;
    avs_read      = 1'h0;
    avs_write     = 1'h0;
    avs_address   = 6'h0;
    avs_writedata = 32'h0;
    want          = '0;
    pump_ok       = 1'h0;
    inrush_seen   = 5'h0;
    miscompares   = 0;
    compares      = 0;
    cyc(20);
    reset <= 1'h0;
    rdc(ADDR_OUTCTL, 32'h1f, 32'h0);
    rdc(ADDR_IRQ_MSK, 32'hff, 32'h0);
    rdc(ADDR_MODE, 32'h1, 32'h0);
    acc(1'h1, ADDR_OUTCTL, 32'h1f);
    cyc(20);
    chk(32'(out_on), 32'h0, "pump unsettled");
    pump_ok <= 1'h1;
    cyc(10);
    chk(32'(out_on), 32'h1f, "held turn-on");
    $display("test done: power-up");
    acc(1'h1, 6'h3c, 32'h0);
    acc(1'h0, 6'h3c, 32'h0);
    chk(rd_data, 32'h0, "unmapped data");
    chk(32'(rd_resp), 32'h3, "unmapped response");
    rdc(ADDR_OUTCTL, 32'h1f, 32'h1f);
    $display("test done: unmapped");
    acc(1'h1, ADDR_IRQ_MSK, 32'h1);
    fault(8'h08, OTS_FILTER_CYC, ADDR_CH_BASE, 32'h2, 32'h1);
    chk(32'(out_on), 32'h1e, "hot channel");
    chk(32'(irq), 32'h1, "irq raised");
    heal(OTS_FILTER_CYC, ADDR_CH_BASE, 32'h2);
    chk(32'(out_on), 32'h1e, "no self restart");
    acc(1'h1, ADDR_CH_BASE, 32'h1);
    cyc(2);
    chk(32'(out_on), 32'h1f, "host restart");
    rdc(ADDR_IRQ_ST, 32'h1, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h0, "irq cleared");
    $display("test done: over-temperature");
    @(posedge core_clk);
    want <= 8'h04;
    cyc(100);
    want <= '0;
    cyc(SUPP_FILTER_CYC + 12);
    chk(32'(out_on), 32'h1f, "glitch");
    rdc(ADDR_DEVST, 32'h8000_0001, 32'h0);
    fault(8'h04, SUPP_FILTER_CYC, ADDR_DEVST, 32'h8000_0001, 32'h8000_0000);
    chk(32'(out_on), 32'h0, "undervoltage");
    chk(32'(irq), 32'h0, "masked event");
    heal(SUPP_FILTER_CYC, ADDR_DEVST, 32'h1);
    chk(32'(out_on), 32'h0, "awaits host");
    acc(1'h1, ADDR_OUTCTL, 32'h1f);
    cyc(2);
    chk(32'(out_on), 32'h1f, "host restart");
    fault(8'h02, SUPP_FILTER_CYC, ADDR_DEVST, 32'h8000_0002, 32'h8000_0000);
    heal(SUPP_FILTER_CYC, ADDR_DEVST, 32'h2);
    $display("test done: supply");
    fault(8'h01, PUMP_FILTER_CYC, ADDR_QUICK, 32'h100, 32'h8000_0000);
    chk(32'(out_on), 32'h0, "pump fault");
    acc(1'h1, ADDR_OUTCTL, 32'h3);
    @(negedge core_clk);
    inrush_seen = 5'h0;
    heal(PUMP_FILTER_CYC, ADDR_QUICK, 32'h100);
    chk(32'(out_on), 32'h3, "deferred turn-on");
    chk(32'(inrush_seen), 32'h3, "inrush windows");
    $display("test done: pump");
    acc(1'h1, ADDR_MODE, 32'h1);
    fault(8'h10, OTS_FILTER_CYC, ADDR_CH_BASE + 6'h04, 32'h2, 32'h2);
    heal(OTS_FILTER_CYC, ADDR_CH_BASE + 6'h04, 32'h2);
    chk(32'(out_on), 32'h1, "fail mode hold");
    acc(1'h1, ADDR_CH_BASE + 6'h04, 32'h1);
    cyc(2);
    chk(32'(out_on), 32'h1, "fail mode write");
    acc(1'h1, ADDR_MODE, 32'h0);
    cyc(2);
    chk(32'(out_on), 32'h3, "mode change");
    acc(1'h1, ADDR_MODE, 32'h1);
    fault(8'h04, SUPP_FILTER_CYC, ADDR_DEVST, 32'h1, 32'h8000_0000);
    heal(SUPP_FILTER_CYC, ADDR_DEVST, 32'h1);
    chk(32'(out_on), 32'h3, "autorestart");
    $display("test done: fail mode");
    stop_test();
  end
endmodule
